// ===== core/fch_pkg.sv
package fch_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0]  FCH_OFF_CTRL        = 8'h00;
    localparam logic [7:0]  FCH_OFF_CHANGE_MASK = 8'h04;
    localparam logic [7:0]  FCH_OFF_SAVE_MASK   = 8'h08;
    localparam logic [7:0]  FCH_OFF_OPT_MASK    = 8'h0C;
    localparam logic [7:0]  FCH_OFF_ARB_STATE   = 8'h10;
    localparam logic [7:0]  FCH_OFF_LAST_CMD    = 8'h14;

    // Control register bit positions.
    localparam int          FCH_CTRL_FABRIC     = 0;
    localparam int          FCH_CTRL_RESV       = 1;
    localparam int          FCH_CTRL_RESERVATION_CAPABILITY_FIELD     = 2;
    localparam int          FCH_CTRL_W          = 3;

    // Reset values of the software registers.
    localparam logic [2:0]  FCH_CTRL_RST        = 3'h0;
    localparam logic [31:0] FCH_CHANGE_MASK_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] FCH_SAVE_MASK_RST   = 32'h0000_0000;
    localparam logic [31:0] FCH_OPT_MASK_RST    = 32'h0000_0000;
    localparam logic [31:0] FCH_FEAT_RST        = 32'h0000_0000;

    // Feature slots: selectors 01h..11h use slot = selector, 80h..83h use 24..27.
    localparam int          FCH_NUM_SLOTS       = 32;
    localparam logic [31:0] FCH_MAND_SLOTS      = 32'h0000_0CB6;
    localparam logic [31:0] FCH_PCIE_SLOTS      = 32'h0000_0300;
    localparam logic [31:0] FCH_RESV_SLOTS      = 32'h0200_0000;
    localparam logic [31:0] FCH_RESERVATION_CAPABILITY_FIELD_SLOTS    = 32'h0C00_0000;
    localparam logic [31:0] FCH_PERSIST_SLOTS   = 32'h0901_0008;
    localparam logic [31:0] FCH_BUFFER_SLOTS    = 32'h0200_5008;
    localparam logic [4:0]  FCH_SLOT_ARB        = 5'h01;
    localparam logic [4:0]  FCH_SLOT_HMB        = 5'h0D;
    localparam logic [7:0]  FCH_SEL_LAST_BASE   = 8'h11;
    localparam logic [5:0]  FCH_SEL_CS_GROUP    = 6'h20;
    localparam logic [2:0]  FCH_SLOT_CS_HI      = 3'h6;

    // Command dword fields.
    localparam int          FCH_PERSIST_BIT     = 31;
    localparam logic [31:0] FCH_ARB_KEEP_MASK   = 32'hFFFF_FF07;
    localparam int          FCH_HCW_LSB         = 24;
    localparam int          FCH_MCW_LSB         = 16;
    localparam int          FCH_LCW_LSB         = 8;
    localparam logic [2:0]  FCH_BURST_UNLIMITED = 3'h7;

    // Completion status codes.
    localparam logic [7:0]  FCH_SC_SUCCESS      = 8'h00;
    localparam logic [7:0]  FCH_SC_INVALID      = 8'h02;
    localparam logic [7:0]  FCH_SC_NOT_SAVEABLE = 8'h0D;
    localparam logic [7:0]  FCH_SC_NOT_CHANGE   = 8'h0E;

    // AXI responses.
    localparam logic [1:0]  FCH_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  FCH_RESP_SLVERR     = 2'h2;

endpackage

// ===== core/fch_feature_handler.sv
// Summary of operation
// - Controller reset returns every non-persistent feature value to its default.
// - Commands after a successful set use the new value immediately.
// - Commands already in flight may see old or new value.
// - Unchangeable feature, differing value: abort with not-changeable status.
// - Unchangeable feature, same value: complete successfully here.
// - Selectors 01,02,04,05,07,0A,0B mandatory; 03,06,0C-11 optional.
// - Selectors 80-83 defined for storage set; 84-BF reserved.
// - Vendor selectors C0-FF: this controller rejects them as invalid.
// - Non-saveable 03,10,80,83 survive controller reset; others lose value unless saved, and 0D is always cleared.
// - 03,0C,0E,81 use a memory buffer; 0D only when read.
// - Memory buffer feature cleared on power state change and reset.
// - 08 and 09 supported on PCIe transport, unsupported on fabric.
// - 81 mandatory with reservation support; 82,83 with nonzero capability.
// - Arbitration takes dword 11; read back in completion dword 0.
// - Bits 31:24 high class weight, count is value plus one.
// - Bits 23:16 medium class weight, count is value plus one.
// - Bits 15:8 low class weight, count is value plus one.
// - Bits 2:0 burst limit as power of two; 111b unlimited.
// - Save requested on a non-saveable feature: abort not-saveable.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module fch_feature_handler
    import fch_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ctrl_reset,
    input  wire logic        i_power_state_change,
    input  wire logic        i_cmd_valid,
    output logic             o_cmd_ready,
    input  wire logic        i_cmd_set,
    input  wire logic [31:0] i_cmd_dw10,
    input  wire logic [31:0] i_cmd_dw11,
    output logic             o_cpl_valid,
    input  wire logic        i_cpl_ready,
    output logic [7:0]       o_cpl_status,
    output logic [31:0]      o_cpl_dw0,
    output logic             o_cpl_uses_buffer,
    output logic [8:0]       o_high_class_count,
    output logic [8:0]       o_medium_class_count,
    output logic [8:0]       o_low_class_count,
    output logic [7:0]       o_queue_burst_limit,
    output logic             o_burst_unlimited,
    input  wire logic [7:0]  i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    input  wire logic [7:0]  i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready
);

    typedef enum logic {FCH_IDLE, FCH_RESP} fch_state_t;
    fch_state_t  state;
    logic [31:0] feat_val [FCH_NUM_SLOTS];
    logic [31:0] saved_slots;
    logic [2:0]  ctrl_reg;
    logic [31:0] change_mask;
    logic [31:0] save_mask;
    logic [31:0] opt_mask;
    logic [15:0] last_cmd;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [7:0]  sel;
    logic        persist;
    logic        take;
    logic        slot_hit;
    logic [4:0]  slot;
    logic [31:0] supp_slots;
    logic        supported;
    logic [31:0] val_new;
    logic        differs;
    logic [7:0]  next_status;
    logic        wr_feat;
    logic [31:0] keep_slots;
    logic [31:0] next_arb;
    assign sel     = i_cmd_dw10[7:0];
    assign persist = i_cmd_dw10[FCH_PERSIST_BIT];
    assign take    = i_cmd_valid && o_cmd_ready;
    // Map a selector onto a storage slot; everything else is reserved or vendor.
    always_comb begin
        slot_hit = 1'b0;
        slot     = 5'h00;
        if (sel != 8'h00 && sel <= FCH_SEL_LAST_BASE) begin
            slot_hit = 1'b1;
            slot     = sel[4:0];
        end else if (sel[7:2] == FCH_SEL_CS_GROUP) begin
            slot_hit = 1'b1;
            slot     = {FCH_SLOT_CS_HI, sel[1:0]};
        end
    end
    always_comb begin
        supp_slots = FCH_MAND_SLOTS | opt_mask;
        if (!ctrl_reg[FCH_CTRL_FABRIC]) begin
            supp_slots = supp_slots | FCH_PCIE_SLOTS;
        end else begin
            supp_slots = supp_slots & ~FCH_PCIE_SLOTS;
        end
        if (ctrl_reg[FCH_CTRL_RESV]) begin
            supp_slots = supp_slots | FCH_RESV_SLOTS;
        end
        if (ctrl_reg[FCH_CTRL_RESERVATION_CAPABILITY_FIELD]) begin
            supp_slots = supp_slots | FCH_RESERVATION_CAPABILITY_FIELD_SLOTS;
        end
    end
    assign supported = slot_hit && supp_slots[slot];
    assign val_new   = (slot == FCH_SLOT_ARB) ? (i_cmd_dw11 & FCH_ARB_KEEP_MASK)
                                              : i_cmd_dw11;
    assign differs   = (val_new != feat_val[slot]);
    always_comb begin
        if (!supported) begin
            next_status = FCH_SC_INVALID;
        end else if (i_cmd_set && persist && !save_mask[slot]) begin
            next_status = FCH_SC_NOT_SAVEABLE;
        end else if (i_cmd_set && !change_mask[slot] && differs) begin
            next_status = FCH_SC_NOT_CHANGE;
        end else begin
            next_status = FCH_SC_SUCCESS;
        end
    end
    // A controller reset in the same cycle wins over a set.
    assign wr_feat    = take && i_cmd_set && (next_status == FCH_SC_SUCCESS) && !i_ctrl_reset;
    assign keep_slots = FCH_PERSIST_SLOTS | saved_slots;
    always_comb begin
        next_arb = feat_val[FCH_SLOT_ARB];
        if (i_ctrl_reset && !keep_slots[FCH_SLOT_ARB]) begin
            next_arb = FCH_FEAT_RST;
        end else if (wr_feat && slot == FCH_SLOT_ARB) begin
            next_arb = val_new;
        end
    end
    // Feature store: writes take effect at the completion edge.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < FCH_NUM_SLOTS; i++) begin
                feat_val[i] <= FCH_FEAT_RST;
            end
            saved_slots <= 32'h0000_0000;
        end else if (i_ctrl_reset) begin
            for (int i = 0; i < FCH_NUM_SLOTS; i++) begin
                if (!keep_slots[i] || i == int'(FCH_SLOT_HMB)) begin
                    feat_val[i] <= FCH_FEAT_RST;
                end
            end
        end else begin
            if (wr_feat) begin
                feat_val[slot] <= val_new;
                if (persist) begin
                    saved_slots[slot] <= 1'b1;
                end
            end
            if (i_power_state_change) begin
                feat_val[FCH_SLOT_HMB] <= FCH_FEAT_RST;
            end
        end
    end

    // Arbitration outputs follow the stored value at the same edge.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_high_class_count   <= 9'h001;
            o_medium_class_count <= 9'h001;
            o_low_class_count    <= 9'h001;
            o_queue_burst_limit  <= 8'h01;
            o_burst_unlimited    <= 1'b0;
        end else begin
            o_high_class_count   <= {1'b0, next_arb[FCH_HCW_LSB +: 8]} + 9'h001;
            o_medium_class_count <= {1'b0, next_arb[FCH_MCW_LSB +: 8]} + 9'h001;
            o_low_class_count    <= {1'b0, next_arb[FCH_LCW_LSB +: 8]} + 9'h001;
            o_queue_burst_limit  <= 8'h01 << next_arb[2:0];
            o_burst_unlimited    <= (next_arb[2:0] == FCH_BURST_UNLIMITED);
        end
    end

    // Command handshake and completion.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state             <= FCH_IDLE;
            o_cmd_ready       <= 1'b1;
            o_cpl_valid       <= 1'b0;
            o_cpl_status      <= FCH_SC_SUCCESS;
            o_cpl_dw0         <= 32'h0000_0000;
            o_cpl_uses_buffer <= 1'b0;
            last_cmd          <= 16'h0000;
        end else begin
            case (state)
                FCH_IDLE: begin
                    if (take) begin
                        state        <= FCH_RESP;
                        o_cmd_ready  <= 1'b0;
                        o_cpl_valid  <= 1'b1;
                        o_cpl_status <= next_status;
                        o_cpl_dw0    <= (!i_cmd_set && supported) ? feat_val[slot] : 32'h0;
                        o_cpl_uses_buffer <= supported && (FCH_BUFFER_SLOTS[slot] ||
                            (!i_cmd_set && slot == FCH_SLOT_HMB));
                        last_cmd     <= {next_status, sel};
                    end
                end
                FCH_RESP: begin
                    if (i_cpl_ready) begin
                        state       <= FCH_IDLE;
                        o_cmd_ready <= 1'b1;
                        o_cpl_valid <= 1'b0;
                    end
                end
                default: begin
                    state       <= FCH_IDLE;
                    o_cmd_ready <= 1'b1;
                    o_cpl_valid <= 1'b0;
                end
            endcase
        end
    end

    // AXI4-Lite write channel: address and data taken in either order.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            o_axi_awready <= 1'b1;
            o_axi_wready  <= 1'b1;
            o_axi_bvalid  <= 1'b0;
            o_axi_bresp   <= FCH_RESP_OKAY;
            ctrl_reg      <= FCH_CTRL_RST;
            change_mask   <= FCH_CHANGE_MASK_RST;
            save_mask     <= FCH_SAVE_MASK_RST;
            opt_mask      <= FCH_OPT_MASK_RST;
        end else begin
            if (i_axi_awvalid && o_axi_awready) begin
                aw_have       <= 1'b1;
                awaddr_q      <= i_axi_awaddr;
                o_axi_awready <= 1'b0;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                w_have       <= 1'b1;
                wdata_q      <= i_axi_wdata;
                wstrb_q      <= i_axi_wstrb;
                o_axi_wready <= 1'b0;
            end
            if (aw_have && w_have && !o_axi_bvalid) begin
                o_axi_bvalid <= 1'b1;
                o_axi_bresp  <= FCH_RESP_OKAY;
                for (int b = 0; b < 4; b++) begin
                    if (wstrb_q[b]) begin
                        case ({awaddr_q[7:2], 2'b00})
                            FCH_OFF_CTRL: begin
                                if (b == 0) begin
                                    ctrl_reg <= wdata_q[FCH_CTRL_W-1:0];
                                end
                            end
                            FCH_OFF_CHANGE_MASK: change_mask[b*8 +: 8] <= wdata_q[b*8 +: 8];
                            FCH_OFF_SAVE_MASK:   save_mask[b*8 +: 8]   <= wdata_q[b*8 +: 8];
                            FCH_OFF_OPT_MASK:    opt_mask[b*8 +: 8]    <= wdata_q[b*8 +: 8];
                            default: ;
                        endcase
                    end
                end
                case ({awaddr_q[7:2], 2'b00})
                    FCH_OFF_CTRL, FCH_OFF_CHANGE_MASK, FCH_OFF_SAVE_MASK, FCH_OFF_OPT_MASK,
                    FCH_OFF_ARB_STATE, FCH_OFF_LAST_CMD: o_axi_bresp <= FCH_RESP_OKAY;
                    default: o_axi_bresp <= FCH_RESP_SLVERR;
                endcase
            end
            if (o_axi_bvalid && i_axi_bready) begin
                o_axi_bvalid  <= 1'b0;
                aw_have       <= 1'b0;
                w_have        <= 1'b0;
                o_axi_awready <= 1'b1;
                o_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_axi_arready <= 1'b1;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= 32'h0000_0000;
            o_axi_rresp   <= FCH_RESP_OKAY;
        end else begin
            if (i_axi_arvalid && o_axi_arready) begin
                o_axi_arready <= 1'b0;
                o_axi_rvalid  <= 1'b1;
                o_axi_rresp   <= FCH_RESP_OKAY;
                case ({i_axi_araddr[7:2], 2'b00})
                    FCH_OFF_CTRL:        o_axi_rdata <= {29'h0, ctrl_reg};
                    FCH_OFF_CHANGE_MASK: o_axi_rdata <= change_mask;
                    FCH_OFF_SAVE_MASK:   o_axi_rdata <= save_mask;
                    FCH_OFF_OPT_MASK:    o_axi_rdata <= opt_mask;
                    FCH_OFF_ARB_STATE:   o_axi_rdata <= feat_val[FCH_SLOT_ARB];
                    FCH_OFF_LAST_CMD:    o_axi_rdata <= {16'h0, last_cmd};
                    default: begin
                        o_axi_rdata <= 32'h0000_0000;
                        o_axi_rresp <= FCH_RESP_SLVERR;
                    end
                endcase
            end else if (o_axi_rvalid && i_axi_rready) begin
                o_axi_rvalid  <= 1'b0;
                o_axi_arready <= 1'b1;
            end
        end
    end

    sequence s_take(logic [7:0] s);
        take && sel == s;
    endsequence
    sequence s_cpl(logic [7:0] sc);
        o_cpl_valid && o_cpl_status == sc;
    endsequence
    property p_reset_default;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ctrl_reset && !keep_slots[FCH_SLOT_ARB] |=> o_high_class_count == 9'h001
            && o_queue_burst_limit == 8'h01 && feat_val[FCH_SLOT_ARB] == FCH_FEAT_RST;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("arbitration kept");
    property p_new_setting;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_take(8'h01) ##0 i_cmd_set && next_status == FCH_SC_SUCCESS && !i_ctrl_reset
            |=> o_cpl_valid && o_high_class_count == {1'b0, $past(i_cmd_dw11[31:24])} + 9'h001
            && o_low_class_count == {1'b0, $past(i_cmd_dw11[15:8])} + 9'h001;
    endproperty
    a_new_setting: assert property (p_new_setting) else $error("new weights not applied");
    property p_not_changeable;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && i_cmd_set && supported && !persist && !change_mask[slot] && differs
            |=> s_cpl(FCH_SC_NOT_CHANGE);
    endproperty
    a_not_changeable: assert property (p_not_changeable) else $error("change not refused");
    property p_same_value;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && i_cmd_set && supported && !persist && !differs |=> s_cpl(FCH_SC_SUCCESS);
    endproperty
    a_same_value: assert property (p_same_value) else $error("same value refused");
    property p_mandatory;
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_take(8'h01) or s_take(8'h0B)) ##0 !i_cmd_set |=> s_cpl(FCH_SC_SUCCESS);
    endproperty
    a_mandatory: assert property (p_mandatory) else $error("mandatory selector refused");
    property p_unsupported;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && (sel == 8'h00 || (sel >= 8'h12 && sel <= 8'h7F) || sel >= 8'h84)
            |=> s_cpl(FCH_SC_INVALID);
    endproperty
    a_unsupported: assert property (p_unsupported) else $error("reserved selector taken");
    property p_fabric;
        @(posedge i_clk) disable iff (!i_rst_n)
        (s_take(8'h08) or s_take(8'h09)) ##0 ctrl_reg[FCH_CTRL_FABRIC]
            |=> s_cpl(FCH_SC_INVALID);
    endproperty
    a_fabric: assert property (p_fabric) else $error("fabric accepted coalescing");
    property p_not_saveable;
        @(posedge i_clk) disable iff (!i_rst_n)
        take && i_cmd_set && persist && supported && !save_mask[slot]
            |=> s_cpl(FCH_SC_NOT_SAVEABLE);
    endproperty
    a_not_saveable: assert property (p_not_saveable) else $error("save not refused");
    property p_buffer;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_take(8'h0D) ##0 supported |=> o_cpl_uses_buffer == !$past(i_cmd_set);
    endproperty
    a_buffer: assert property (p_buffer) else $error("buffer flag wrong");
    property p_hmb_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_power_state_change |=> feat_val[FCH_SLOT_HMB] == FCH_FEAT_RST;
    endproperty
    a_hmb_clear: assert property (p_hmb_clear) else $error("buffer feature kept");
    property p_readback;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_take(8'h01) ##0 !i_cmd_set |=> o_cpl_dw0[7:3] == 5'h00
            && o_cpl_dw0 == $past(feat_val[FCH_SLOT_ARB]);
    endproperty
    a_readback: assert property (p_readback) else $error("arbitration readback wrong");
    property p_cpl_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_cpl_valid && !i_cpl_ready |=> o_cpl_valid && $stable(o_cpl_status) && !o_cmd_ready;
    endproperty
    a_cpl_hold: assert property (p_cpl_hold) else $error("completion dropped");
endmodule

// ===== sim/fch_host_model.sv
`timescale 1ns/100ps
module fch_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_cmd_ready,
    input  wire logic        i_cpl_valid,
    output logic             o_cmd_valid = 1'b0,
    output logic             o_cmd_set   = 1'b0,
    output logic [31:0]      o_cmd_dw10  = 32'h0,
    output logic [31:0]      o_cmd_dw11  = 32'h0,
    output logic             o_cpl_ready = 1'b0
);
    // Only one command is outstanding; the next waits until the completion is taken.
    task automatic cmd(input logic s, input logic [31:0] d10, input logic [31:0] d11);
        @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_set   <= s;
        o_cmd_dw10  <= d10;
        o_cmd_dw11  <= d11;
        do @(posedge i_clk); while (i_cmd_ready !== 1'b1);
        o_cmd_valid <= 1'b0;
        o_cmd_dw10  <= ~d10;
        o_cmd_dw11  <= ~d11;
        while (i_cpl_valid !== 1'b1) @(posedge i_clk);
        // Ready follows the shown completion, so the design must hold it for a cycle.
        o_cpl_ready <= 1'b1;
        @(posedge i_clk);
        o_cpl_ready <= 1'b0;
    endtask
endmodule

// ===== sim/fch_feature_handler_tb_top.sv
`timescale 1ns/100ps
module fch_feature_handler_tb_top
    import fch_pkg::*;
;
    logic        clk, cv, cs, plr, crdy, plv, ub, bu, awr, wr, bv, arr, rv;
    logic        rst_n = 1'b0, cr = 1'b0, psc = 1'b0, awv = 1'b0, wv = 1'b0;
    logic        bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [31:0] d10, d11, dw0, rd, wd = 32'h0;
    logic [8:0]  hc, mc, lc;
    logic [7:0]  st, bl, awa = 8'h0, ara = 8'h0;
    logic [1:0]  br, rr;
    wire  [35:0] arb = {hc, mc, lc, bl, bu};
    int          err_total = 0;
    int          compares = 0;
    int          cyc = 0;
    logic [15:0] tbl [20] = '{16'h0100, 16'h0200, 16'h0400, 16'h0500, 16'h0700, 16'h0A00,
        16'h0B00, 16'h0800, 16'h0900, 16'h0002, 16'h1202, 16'h7702, 16'h7802, 16'h7F02,
        16'h8402, 16'hBF02, 16'hC002, 16'hFF02, 16'h0602, 16'h8102};

    fch_feature_handler fch_feature_handler_i (.i_clk(clk), .i_rst_n(rst_n),
        .i_ctrl_reset(cr), .i_power_state_change(psc), .i_cmd_valid(cv), .o_cmd_ready(crdy),
        .i_cmd_set(cs), .i_cmd_dw10(d10), .i_cmd_dw11(d11), .o_cpl_valid(plv),
        .i_cpl_ready(plr), .o_cpl_status(st), .o_cpl_dw0(dw0), .o_cpl_uses_buffer(ub),
        .o_high_class_count(hc), .o_medium_class_count(mc), .o_low_class_count(lc),
        .o_queue_burst_limit(bl), .o_burst_unlimited(bu), .i_axi_awaddr(awa),
        .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(4'hF),
        .i_axi_wvalid(wv), .o_axi_wready(wr), .o_axi_bresp(br), .o_axi_bvalid(bv),
        .i_axi_bready(bre), .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr),
        .o_axi_rdata(rd), .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rre));

    fch_host_model fch_host_model_i (.i_clk(clk), .i_cmd_ready(crdy), .i_cpl_valid(plv),
        .o_cmd_valid(cv), .o_cmd_set(cs), .o_cmd_dw10(d10), .o_cmd_dw11(d11),
        .o_cpl_ready(plr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (err_total == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        compares = compares + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Expected arbitration outputs: weights are stored minus one, burst is a power of two.
    function automatic logic [35:0] aexp(input logic [31:0] v);
        return {{1'b0, v[31:24]} + 9'h001, {1'b0, v[23:16]} + 9'h001,
                {1'b0, v[15:8]} + 9'h001, 8'h01 << v[2:0], v[2:0] == 3'h7};
    endfunction

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er = FCH_RESP_OKAY);
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
        chk({62'h0, br}, {62'h0, er});
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
        chk({30'h0, rr, rd}, {30'h0, er, e});
    endtask

    task automatic fc(input logic s, input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] ed, input logic [7:0] es, input logic eb);
        fch_host_model_i.cmd(s, a, b);
        chk(64'(st), 64'(es));
        if (es == FCH_SC_SUCCESS) chk({31'h0, ub, dw0}, {31'h0, eb, ed});
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk(64'(arb), 64'(aexp(32'h0)));
        axr(FCH_OFF_CTRL, 32'h0, FCH_RESP_OKAY);
        axr(FCH_OFF_CHANGE_MASK, 32'hFFFF_FFFF, FCH_RESP_OKAY);
        axr(FCH_OFF_SAVE_MASK, 32'h0, FCH_RESP_OKAY);
        axr(FCH_OFF_OPT_MASK, 32'h0, FCH_RESP_OKAY);
        axr(8'h40, 32'h0, FCH_RESP_SLVERR);
        axw(8'h40, 32'h1, FCH_RESP_SLVERR);
        foreach (tbl[k]) begin
            fc(1'b0, 32'(tbl[k][15:8]), 32'h0, 32'h0, tbl[k][7:0], 1'b0);
        end
        fc(1'b1, 32'h01, 32'h0302_01FB, 32'h0, FCH_SC_SUCCESS, 1'b0);
        chk(64'(arb), 64'(aexp(32'h0302_01FB)));
        fc(1'b0, 32'h01, 32'h0, 32'h0302_0103, FCH_SC_SUCCESS, 1'b0);
        fc(1'b1, 32'h01, 32'hFFFF_FF07, 32'h0, FCH_SC_SUCCESS, 1'b0);
        chk(64'(arb), 64'(aexp(32'hFFFF_FF07)));
        axr(FCH_OFF_ARB_STATE, 32'hFFFF_FF07, FCH_RESP_OKAY);
        fc(1'b1, 32'h8000_0002, 32'h0, 32'h0, FCH_SC_NOT_SAVEABLE, 1'b0);
        axr(FCH_OFF_LAST_CMD, 32'h0000_0D02, FCH_RESP_OKAY);
        axw(FCH_OFF_CHANGE_MASK, 32'hFFFF_FFEF);
        fc(1'b1, 32'h04, 32'h7, 32'h0, FCH_SC_NOT_CHANGE, 1'b0);
        fc(1'b1, 32'h04, 32'h0, 32'h0, FCH_SC_SUCCESS, 1'b0);
        axw(FCH_OFF_CHANGE_MASK, 32'hFFFF_FFFF);
        axw(FCH_OFF_CTRL, 32'h7);
        axr(FCH_OFF_CTRL, 32'h7, FCH_RESP_OKAY);
        fc(1'b0, 32'h08, 32'h0, 32'h0, FCH_SC_INVALID, 1'b0);
        fc(1'b0, 32'h81, 32'h0, 32'h0, FCH_SC_SUCCESS, 1'b1);
        fc(1'b0, 32'h82, 32'h0, 32'h0, FCH_SC_SUCCESS, 1'b0);
        axw(FCH_OFF_OPT_MASK, 32'h0001_2000);
        fc(1'b1, 32'h10, 32'h5, 32'h0, FCH_SC_SUCCESS, 1'b0);
        fc(1'b1, 32'h04, 32'h7, 32'h0, FCH_SC_SUCCESS, 1'b0);
        @(posedge clk) cr <= 1'b1;
        @(posedge clk) cr <= 1'b0;
        @(negedge clk);
        chk(64'(arb), 64'(aexp(32'h0)));
        fc(1'b0, 32'h10, 32'h0, 32'h5, FCH_SC_SUCCESS, 1'b0);
        fc(1'b0, 32'h04, 32'h0, 32'h0, FCH_SC_SUCCESS, 1'b0);
        fc(1'b1, 32'h0D, 32'h9, 32'h0, FCH_SC_SUCCESS, 1'b0);
        fc(1'b0, 32'h0D, 32'h0, 32'h9, FCH_SC_SUCCESS, 1'b1);
        @(posedge clk) psc <= 1'b1;
        @(posedge clk) psc <= 1'b0;
        fc(1'b0, 32'h0D, 32'h0, 32'h0, FCH_SC_SUCCESS, 1'b1);
        wrap_up();
    end
endmodule
